/* dadm_regs.vh */
`ifndef DADM_REGS_VH
`define DADM_REGS_VH

// Addressing mode codes (one-hot)
`define DADM_MODE_W          4
`define DADM_MODE_DIDX       4'h1
`define DADM_MODE_DIR_IMM    4'h2
`define DADM_MODE_DIDX_IMM   4'h4
`define DADM_MODE_DIR_DIR    4'h8

// Operation codes
`define DADM_OP_W            3
`define DADM_OP_MOV          3'h0
`define DADM_OP_ADD          3'h1
`define DADM_OP_SUB          3'h2
`define DADM_OP_AND          3'h3
`define DADM_OP_OR           3'h4
`define DADM_OP_XOR          3'h5

// Instruction lengths in bytes
`define DADM_LEN_DIDX        2'h2
`define DADM_LEN_IMM         2'h3
`define DADM_LEN_MEM2MEM     2'h3

`endif

/* dadm_decode.v */
`timescale 1ns/1ps
`include "dadm_regs.vh"

// Overview of operation
// - Destination indexed mode writes to operand 1 plus the index register, in RAM or register space.
// - Destination indexed mode takes the accumulator as source and, for arithmetic, the destination byte as second source.
// - Destination indexed instructions are two bytes long for program counter advance.
// - Direct destination with immediate source uses operand 1 as address, operand 2 as value, destination byte as second source.
// - Both immediate-source destination modes are three bytes long.
// - Indexed destination with immediate source addresses operand 1 plus index, in RAM or register space.
// - The memory-to-memory mode is accepted only with the move operation.
// - Memory-to-memory move reads RAM at operand 2 and writes RAM at operand 1, never register space.
// - A memory-to-memory move is three bytes long.
module dadm_decode #(
  parameter DW = 8
) (
  // Clock, reset, enable
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          ce,
  // Instruction in
  input  wire          instr_valid,
  input  wire [3:0]    mode,
  input  wire [2:0]    op,
  input  wire          reg_space,
  input  wire [DW-1:0] operand1,
  input  wire [DW-1:0] operand2,
  // Core state
  input  wire [DW-1:0] acc,
  input  wire [DW-1:0] idx,
  // Memory read (combinational address, data same cycle)
  output reg  [DW-1:0] rd_addr,
  output reg           rd_reg_space,
  output wire          rd_en,
  input  wire [DW-1:0] rd_data,
  // Result write
  output reg           wr_en,
  output reg           wr_reg_space,
  output reg  [DW-1:0] wr_addr,
  output reg  [DW-1:0] wr_data,
  // Decode status
  output reg  [1:0]    instr_len,
  output reg           len_valid,
  output reg           illegal
);

  reg [DW-1:0] dst_addr;
  reg [DW-1:0] src_val;
  reg [DW-1:0] result;
  reg [1:0]    len_next;
  reg          dst_reg;
  reg          needs_dst;
  reg          bad;

  // Full-width sums, cut to DW on purpose so indexed addresses wrap
  wire [DW:0]  idx_sum  = {1'b0, operand1} + {1'b0, idx};
  wire [DW:0]  add_sum  = {1'b0, rd_data} + {1'b0, src_val};
  wire [DW:0]  sub_diff = {1'b0, rd_data} - {1'b0, src_val};

  always @* begin
    dst_addr  = operand1;
    src_val   = acc;
    dst_reg   = reg_space;
    needs_dst = (op != `DADM_OP_MOV);
    len_next  = `DADM_LEN_DIDX;
    bad       = 1'b0;
    case (mode)
      `DADM_MODE_DIDX: begin
        dst_addr = idx_sum[DW-1:0];
        src_val  = acc;
        len_next = `DADM_LEN_DIDX;
      end
      `DADM_MODE_DIR_IMM: begin
        dst_addr = operand1;
        src_val  = operand2;
        len_next = `DADM_LEN_IMM;
      end
      `DADM_MODE_DIDX_IMM: begin
        dst_addr = idx_sum[DW-1:0];
        src_val  = operand2;
        len_next = `DADM_LEN_IMM;
      end
      `DADM_MODE_DIR_DIR: begin
        dst_addr  = operand1;
        src_val   = rd_data;
        dst_reg   = 1'b0;
        needs_dst = 1'b0;
        len_next  = `DADM_LEN_MEM2MEM;
        bad       = (op != `DADM_OP_MOV);
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  // Read port: destination for arithmetic, or source for memory move
  always @* begin
    if (mode == `DADM_MODE_DIR_DIR) begin
      rd_addr      = operand2;
      rd_reg_space = 1'b0;
    end else begin
      rd_addr      = dst_addr;
      rd_reg_space = dst_reg;
    end
  end

  assign rd_en = instr_valid & ~bad & (needs_dst | (mode == `DADM_MODE_DIR_DIR));

  always @* begin
    case (op)
      `DADM_OP_MOV: result = src_val;
      `DADM_OP_ADD: result = add_sum[DW-1:0];
      `DADM_OP_SUB: result = sub_diff[DW-1:0];
      `DADM_OP_AND: result = rd_data & src_val;
      `DADM_OP_OR:  result = rd_data | src_val;
      `DADM_OP_XOR: result = rd_data ^ src_val;
      default:      result = src_val;
    endcase
  end

  // Accumulator is never written here; only memory destinations
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_en        <= 1'b0;
      wr_reg_space <= 1'b0;
      wr_addr      <= {DW{1'b0}};
      wr_data      <= {DW{1'b0}};
      instr_len    <= 2'h0;
      len_valid    <= 1'b0;
      illegal      <= 1'b0;
    end else if (ce) begin
      wr_en     <= instr_valid & ~bad;
      len_valid <= instr_valid;
      illegal   <= instr_valid & bad;
      if (instr_valid) begin
        wr_reg_space <= dst_reg;
        wr_addr      <= dst_addr;
        wr_data      <= result;
        instr_len    <= len_next;
      end
    end
  end

endmodule

/* dadm_checker.sv */
`timescale 1ns/1ps
module dadm_checker (
  input wire       clk_sys, rst, ce, instr_valid, rd_reg_space, wr_en, wr_reg_space, illegal,
  input wire [3:0] mode,
  input wire [2:0] op,
  input wire [7:0] operand1, operand2, idx, rd_addr, wr_addr,
  input wire [1:0] instr_len
);
  wire go = ce && instr_valid;
  wire ar = op != 3'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence ram_wr; wr_en && !wr_reg_space; endsequence
  AST_XADR: assert property (go && mode == 4'h1 && ar |-> rd_addr == operand1 + idx)
    else $error("index addr");
  AST_IADR: assert property (go && mode == 4'h4 && ar |-> rd_addr == operand1 + idx)
    else $error("index imm addr");
  AST_XLEN: assert property (go && mode == 4'h1 |=> instr_len == 2'h2)
    else $error("index len");
  AST_ILEN: assert property (go && (mode == 4'h2 || mode == 4'h4) |=> instr_len == 2'h3)
    else $error("imm len");
  AST_MOVO: assert property (go && mode == 4'h8 && ar |=> illegal && !wr_en)
    else $error("pair op");
  AST_MRAM: assert property (go && mode == 4'h8 && !ar |->
    !rd_reg_space && rd_addr == operand2 ##1 ram_wr) else $error("move space");
  AST_MLEN: assert property (go && mode == 4'h8 && !ar |=> instr_len == 2'h3)
    else $error("move len");
  AST_DADR: assert property (go && mode == 4'h2 |=> wr_addr == $past(operand1))
    else $error("direct addr");
  AST_HOLD: assert property (!ce |=> $stable(wr_en) && $stable(wr_addr) && $stable(illegal))
    else $error("enable hold");
endmodule
bind dadm_decode dadm_checker i_dadm_checker (.*);

/* dest_addressing_mode_decode_bench.sv */
`timescale 1ns/1ps
module dest_addressing_mode_decode_bench;
  reg         clk_sys = 0, rst = 1, instr_valid = 0, reg_space = 0, ce = 1;
  reg  [3:0]  mode = 0;
  reg  [2:0]  op = 0;
  reg  [7:0]  operand1 = 0, operand2 = 0, acc = 0, idx = 0, a, s, d, r;
  reg  [21:0] ev = 0, got;
  wire [7:0]  rd_addr, wr_addr, wr_data;
  wire [1:0]  instr_len;
  wire        rd_reg_space, wr_en, wr_reg_space, len_valid, illegal;
  integer     seed = 32'he110, miscompares = 0, checks = 0, cyc = 0, i, ei = 0;
  task results;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Memory contents derived from address and space
  dadm_decode i_dadm_decode (.*, .rd_en(),
    .rd_data(rd_addr ^ {8{rd_reg_space}} ^ 8'h5a));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 2000) begin miscompares++; results; end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    for (i = 0; i <= 600; i = i + 1) begin
      @(posedge clk_sys);
      mode <= 4'h1 << ({$random(seed)} % 5);
      op <= {$random(seed)} % 6;
      {operand1, operand2, acc, idx} <= $random(seed);
      reg_space <= $random(seed) % 2 != 0;
      instr_valid <= i < 600;
      ce <= ({$random(seed)} % 4) != 0;
      #1;
      got = {wr_en, illegal, ei ? 20'h0 : {len_valid, instr_len, wr_reg_space, wr_addr, wr_data}};
      checks = checks + 1;
      if (got !== ev) begin
        miscompares = miscompares + 1;
        $display("mismatch %0t %h %h", $time, got, ev);
      end
      // Outputs hold through a cycle with the enable low
      if (ce) begin
        ei = mode == 4'h0 || (mode[3] && op != 3'h0);
        a = (mode[0] || mode[2]) ? operand1 + idx : operand1;
        s = mode[0] ? acc : mode[3] ? operand2 ^ 8'h5a : operand2;
        d = a ^ {8{reg_space && !mode[3]}} ^ 8'h5a;
        r = op == 3'h1 ? d + s : op == 3'h2 ? d - s : op == 3'h3 ? d & s :
            op == 3'h4 ? d | s : op == 3'h5 ? d ^ s : s;
        ev = ei ? 22'h100000 : {3'b101, mode[0] ? 2'h2 : 2'h3, reg_space && !mode[3], a, r};
      end
    end
    $display("decode test done");
    results;
  end
endmodule
